/* hw/hpa_i2c_target.sv */
/*
 * Bus target and control port of a stereo headphone amplifier: address and
 * general-call decode, pointer byte, register read and write, amplifier controls.
 * Assumes SCL and SDA arrive asynchronously and are oversampled by clk_sys at
 * several times the bus rate; SDA is open drain, pulled high outside.
 */
// Notes on behaviour
// - answer address 1100000 only, ignore every other non-general-call address.
// - address byte bit 0 selects direction: one reads, zero writes.
// - general call then command 06h is acknowledged and resets the logic.
// - general-call reset returns every register to its power-on value.
// - first byte after an acknowledged write to address 1100000 is latched as pointer.
// - only pointer bits 2..0 select a register, the upper five are ignored.
// - pointers 00, 05 and 07 are empty and are not acknowledged.
// - pointers 1..4 and 6 map to mode, volume, float, id and test.
// - mode bit 7 set turns the left amplifier on, default off.
// - mode bit 6 set turns the right amplifier on, default off.
// - mode bits 5..2 are reserved and always read zero.
// - mode bit 1 reads one during thermal shutdown, else zero.
// - mode bit 0 set is software shutdown with charge pump off.
`timescale 1ns/10ps
`include "hpa_params.svh"

module hpa_i2c_target (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   // bus pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // analog status
   input  wire logic       thermal_in,
   // amplifier controls
   output logic            left_amp_enable,
   output logic            right_amp_enable,
   output logic            soft_shutdown,
   output logic            mute_left,
   output logic            mute_right,
   output logic      [4:0] volume_level,
   output logic            float_left,
   output logic            float_right,
   output logic      [7:0] test_value
);

   logic [2:0]          pins_s;
   logic                scl_s;
   logic                sda_s;
   logic                therm_s;
   hpa_pkg::hpa_state_t state_q;
   hpa_pkg::hpa_state_t state_d;
   logic [3:0]          bitcnt_q;
   logic [3:0]          bitcnt_d;
   hpa_pkg::hpa_byte_t  shift_q;
   hpa_pkg::hpa_byte_t  shift_d;
   logic [2:0]          ptr_q;
   logic [2:0]          ptr_d;
   logic                rw_q;
   logic                rw_d;
   logic                gc_q;
   logic                gc_d;
   logic                mack_q;
   logic                mack_d;
   logic                oe_q;
   logic                oe_d;
   logic                scl_prev_q;
   logic                sda_prev_q;
   logic                wr_en;
   logic                soft_rst;
   logic [7:0]          rdata;
   logic [7:0]          mode_q;
   logic [7:0]          vol_q;
   logic [7:0]          float_q;
   logic [7:0]          test_q;
   logic                scl_rise;
   logic                scl_fall;
   logic                bus_start;
   logic                bus_stop;
   logic                byte_done;

   hpa_sync #(
      .W (3)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .async_in ({thermal_in, sda_in, scl_in}),
      .sync_out (pins_s)
   );

   assign scl_s   = pins_s[0];
   assign sda_s   = pins_s[1];
   assign therm_s = pins_s[2];

   hpa_regbank u_regs (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .soft_rst (soft_rst),
      .wr_en    (wr_en),
      .addr     (ptr_q),
      .wdata    (shift_q),
      .rdata    (rdata),
      .thermal  (therm_s),
      .mode_q   (mode_q),
      .vol_q    (vol_q),
      .float_q  (float_q),
      .test_q   (test_q)
   );

   // bus conditions seen on the synchronised pins
   assign scl_rise  = scl_s && !scl_prev_q;
   assign scl_fall  = !scl_s && scl_prev_q;
   assign bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
   assign bus_stop  = scl_s && scl_prev_q && !sda_prev_q && sda_s;
   assign byte_done = scl_fall && (bitcnt_q == `HPA_BYTE_BITS);

   always_comb begin
      state_d  = state_q;
      bitcnt_d = bitcnt_q;
      shift_d  = shift_q;
      ptr_d    = ptr_q;
      rw_d     = rw_q;
      gc_d     = gc_q;
      mack_d   = mack_q;
      oe_d     = oe_q;
      wr_en    = 1'b0;
      soft_rst = 1'b0;
      if (bus_start) begin
         state_d  = hpa_pkg::HPA_ADDR;
         bitcnt_d = 4'h0;
         oe_d     = 1'b0;
      end else if (bus_stop) begin
         state_d = hpa_pkg::HPA_IDLE;
         oe_d    = 1'b0;
      end else begin
         case (state_q)
            hpa_pkg::HPA_IDLE: begin
               oe_d = 1'b0;
            end
            hpa_pkg::HPA_ADDR, hpa_pkg::HPA_PTR, hpa_pkg::HPA_WDATA, hpa_pkg::HPA_GCMD: begin
               if (scl_rise && bitcnt_q != `HPA_BYTE_BITS) begin
                  shift_d  = {shift_q[6:0], sda_s};
                  bitcnt_d = bitcnt_q + 4'h1;
               end else if (byte_done) begin
                  bitcnt_d = 4'h0;
                  state_d  = hpa_pkg::HPA_IDLE;
                  case (state_q)
                     hpa_pkg::HPA_ADDR: begin
                        rw_d = shift_q[0];
                        gc_d = (shift_q[7:1] == `HPA_GCALL_ADDR);
                        if (shift_q[7:1] == `HPA_TARGET_ADDR &&
                            (!shift_q[0] || hpa_pkg::hpa_reg_present(ptr_q))) begin
                           state_d = hpa_pkg::HPA_ADDR_ACK;
                           oe_d    = 1'b1;
                        end else if (shift_q[7:1] == `HPA_GCALL_ADDR && !shift_q[0]) begin
                           state_d = hpa_pkg::HPA_ADDR_ACK;
                           oe_d    = 1'b1;
                        end
                     end
                     hpa_pkg::HPA_PTR: begin
                        ptr_d = shift_q[2:0];
                        if (hpa_pkg::hpa_reg_present(shift_q[2:0])) begin
                           state_d = hpa_pkg::HPA_PTR_ACK;
                           oe_d    = 1'b1;
                        end
                     end
                     hpa_pkg::HPA_WDATA: begin
                        wr_en   = 1'b1;
                        state_d = hpa_pkg::HPA_WDATA_ACK;
                        oe_d    = 1'b1;
                     end
                     default: begin
                        if (shift_q == `HPA_GCALL_RESET) begin
                           state_d = hpa_pkg::HPA_GCMD_ACK;
                           oe_d    = 1'b1;
                        end
                     end
                  endcase
               end
            end
            hpa_pkg::HPA_ADDR_ACK: begin
               if (scl_fall) begin
                  oe_d = 1'b0;
                  if (gc_q) begin
                     state_d = hpa_pkg::HPA_GCMD;
                  end else if (rw_q) begin
                     // rdata has tracked ptr_q for many cycles already
                     state_d  = hpa_pkg::HPA_RDATA;
                     shift_d  = rdata;
                     oe_d     = !rdata[7];
                     bitcnt_d = 4'h1;
                  end else begin
                     state_d = hpa_pkg::HPA_PTR;
                  end
               end
            end
            hpa_pkg::HPA_PTR_ACK, hpa_pkg::HPA_WDATA_ACK: begin
               if (scl_fall) begin
                  oe_d    = 1'b0;
                  state_d = hpa_pkg::HPA_WDATA;
               end
            end
            hpa_pkg::HPA_GCMD_ACK: begin
               if (scl_fall) begin
                  oe_d     = 1'b0;
                  soft_rst = 1'b1;
                  ptr_d    = 3'h0;
                  state_d  = hpa_pkg::HPA_IDLE;
               end
            end
            hpa_pkg::HPA_RDATA: begin
               if (scl_fall) begin
                  if (bitcnt_q == `HPA_BYTE_BITS) begin
                     oe_d    = 1'b0;
                     state_d = hpa_pkg::HPA_RDATA_ACK;
                  end else begin
                     shift_d  = {shift_q[6:0], 1'b0};
                     oe_d     = !shift_q[6];
                     bitcnt_d = bitcnt_q + 4'h1;
                  end
               end
            end
            hpa_pkg::HPA_RDATA_ACK: begin
               if (scl_rise) begin
                  mack_d = !sda_s;
               end else if (scl_fall) begin
                  // same register again, no auto increment
                  if (mack_q) begin
                     state_d  = hpa_pkg::HPA_RDATA;
                     shift_d  = rdata;
                     oe_d     = !rdata[7];
                     bitcnt_d = 4'h1;
                  end else begin
                     state_d = hpa_pkg::HPA_IDLE;
                  end
               end
            end
            default: begin
               state_d = hpa_pkg::HPA_IDLE;
               oe_d    = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q    <= hpa_pkg::HPA_IDLE;
         bitcnt_q   <= 4'h0;
         shift_q    <= 8'h00;
         ptr_q      <= 3'h0;
         rw_q       <= 1'b0;
         gc_q       <= 1'b0;
         mack_q     <= 1'b0;
         oe_q       <= 1'b0;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         state_q    <= state_d;
         bitcnt_q   <= bitcnt_d;
         shift_q    <= shift_d;
         ptr_q      <= ptr_d;
         rw_q       <= rw_d;
         gc_q       <= gc_d;
         mack_q     <= mack_d;
         oe_q       <= oe_d;
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   // open drain: only ever pull low
   assign sda_out = 1'b0;
   assign sda_oe  = oe_q;

   assign left_amp_enable  = mode_q[`HPA_MODE_LEFT];
   assign right_amp_enable = mode_q[`HPA_MODE_RIGHT];
   assign soft_shutdown    = mode_q[`HPA_MODE_SHDN];
   assign mute_left        = vol_q[`HPA_VOL_MUTEL];
   assign mute_right       = vol_q[`HPA_VOL_MUTER];
   assign volume_level     = vol_q[`HPA_VOL_HI:`HPA_VOL_LO];
   assign float_left       = float_q[`HPA_FLOAT_L];
   assign float_right      = float_q[`HPA_FLOAT_R];
   assign test_value       = test_q;

   chk_foreign_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_q == hpa_pkg::HPA_ADDR && byte_done && !bus_start && !bus_stop &&
       shift_q[7:1] != `HPA_TARGET_ADDR && shift_q[7:1] != `HPA_GCALL_ADDR)
      |=> (state_q == hpa_pkg::HPA_IDLE) && !sda_oe)
      else $error("foreign address was answered");

   chk_dir_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_q == hpa_pkg::HPA_ADDR && byte_done && !bus_start && !bus_stop)
      |=> rw_q == $past(shift_q[0]))
      else $error("direction bit not taken from address byte");

   chk_gcall_ack: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_q == hpa_pkg::HPA_GCMD && byte_done && !bus_start && !bus_stop &&
       shift_q == `HPA_GCALL_RESET) |=> sda_oe ##1 (sda_oe || soft_rst))
      else $error("general call reset not acknowledged");

   chk_ptr_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_q == hpa_pkg::HPA_PTR && byte_done && !bus_start && !bus_stop)
      |=> ptr_q == $past(shift_q[2:0]))
      else $error("pointer not latched from low three bits");

   chk_empty_nack: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_q == hpa_pkg::HPA_PTR && byte_done && !bus_start && !bus_stop &&
       !hpa_pkg::hpa_reg_present(shift_q[2:0])) |=> !sda_oe [*2])
      else $error("empty pointer was acknowledged");

endmodule

/* hw/hpa_params.svh */
/*
 * Constants of the headphone amplifier control port: bus addresses, register
 * pointers, field positions, write masks and reset values.
 * Assumes it is included by bare name wherever these values are used.
 */
`ifndef HPA_PARAMS_SVH
`define HPA_PARAMS_SVH

// bus addresses and commands
`define HPA_TARGET_ADDR   7'h60
`define HPA_GCALL_ADDR    7'h00
`define HPA_GCALL_RESET   8'h06

// register pointers
`define HPA_REG_MODE      3'h1
`define HPA_REG_VOL       3'h2
`define HPA_REG_FLOAT     3'h3
`define HPA_REG_ID        3'h4
`define HPA_REG_TEST      3'h6

// field positions
`define HPA_MODE_LEFT     7
`define HPA_MODE_RIGHT    6
`define HPA_MODE_THERM    1
`define HPA_MODE_SHDN     0
`define HPA_VOL_MUTEL     7
`define HPA_VOL_MUTER     6
`define HPA_VOL_HI        5
`define HPA_VOL_LO        1
`define HPA_FLOAT_L       1
`define HPA_FLOAT_R       0

// writable bits per register
`define HPA_MODE_WMASK    8'hC1
`define HPA_VOL_WMASK     8'hFE
`define HPA_FLOAT_WMASK   8'h03
`define HPA_TEST_WMASK    8'hFF

// reset values
`define HPA_MODE_RST      8'h00
`define HPA_VOL_RST       8'hC0
`define HPA_FLOAT_RST     8'h00
`define HPA_TEST_RST      8'h00
// identification value is arbitrary
`define HPA_CHIP_ID       8'h00

// bits per byte on the bus
`define HPA_BYTE_BITS     4'h8

`endif

/* hw/hpa_pkg.sv */
/*
 * Types and shared decode for the headphone amplifier control port.
 * Assumes hpa_params.svh is on the include path.
 */
`include "hpa_params.svh"

package hpa_pkg;

   typedef logic [7:0] hpa_byte_t;

   typedef enum logic [10:0] {
      HPA_IDLE      = 11'h001,
      HPA_ADDR      = 11'h002,
      HPA_ADDR_ACK  = 11'h004,
      HPA_PTR       = 11'h008,
      HPA_PTR_ACK   = 11'h010,
      HPA_WDATA     = 11'h020,
      HPA_WDATA_ACK = 11'h040,
      HPA_RDATA     = 11'h080,
      HPA_RDATA_ACK = 11'h100,
      HPA_GCMD      = 11'h200,
      HPA_GCMD_ACK  = 11'h400
   } hpa_state_t;

   // true for pointers that select an implemented register
   function automatic logic hpa_reg_present(input logic [2:0] ptr);
      return (ptr == `HPA_REG_MODE) || (ptr == `HPA_REG_VOL) || (ptr == `HPA_REG_FLOAT) ||
             (ptr == `HPA_REG_ID) || (ptr == `HPA_REG_TEST);
   endfunction

endpackage

/* hw/hpa_sync.sv */
/*
 * Two-flop synchroniser for a group of asynchronous level inputs.
 * Assumes each bit is an independent level; no bus coherence is implied.
 */
`timescale 1ns/10ps

module hpa_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // idle bus level is high, so reset to ones
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta_q   <= '1;
         sync_out <= '1;
      end else begin
         meta_q   <= meta_d;
         sync_out <= sync_d;
      end
   end

endmodule

/* hw/hpa_regbank.sv */
/*
 * Control register bank: mode, volume/mute, output float, identification and
 * test registers, with a registered read port.
 * Assumes a single-cycle write strobe and a synchronised thermal level.
 */
`timescale 1ns/10ps
`include "hpa_params.svh"

module hpa_regbank (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       soft_rst,
   // access port
   input  wire logic       wr_en,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata,
   // status
   input  wire logic       thermal,
   // controls
   output logic      [7:0] mode_q,
   output logic      [7:0] vol_q,
   output logic      [7:0] float_q,
   output logic      [7:0] test_q
);

   logic [7:0] mode_d;
   logic [7:0] vol_d;
   logic [7:0] float_d;
   logic [7:0] test_d;
   logic [7:0] rdata_d;
   logic [7:0] mode_view;

   always_comb begin
      mode_d  = mode_q;
      vol_d   = vol_q;
      float_d = float_q;
      test_d  = test_q;
      if (soft_rst) begin
         mode_d  = `HPA_MODE_RST;
         vol_d   = `HPA_VOL_RST;
         float_d = `HPA_FLOAT_RST;
         test_d  = `HPA_TEST_RST;
      end else if (wr_en) begin
         // read-only bits are masked off
         case (addr)
            `HPA_REG_MODE:  mode_d  = wdata & `HPA_MODE_WMASK;
            `HPA_REG_VOL:   vol_d   = wdata & `HPA_VOL_WMASK;
            `HPA_REG_FLOAT: float_d = wdata & `HPA_FLOAT_WMASK;
            `HPA_REG_TEST:  test_d  = wdata & `HPA_TEST_WMASK;
            default:        mode_d  = mode_q;
         endcase
      end
      mode_view = mode_q;
      mode_view[`HPA_MODE_THERM] = thermal;
      case (addr)
         `HPA_REG_MODE:  rdata_d = mode_view;
         `HPA_REG_VOL:   rdata_d = vol_q;
         `HPA_REG_FLOAT: rdata_d = float_q;
         `HPA_REG_ID:    rdata_d = `HPA_CHIP_ID;
         `HPA_REG_TEST:  rdata_d = test_q;
         default:        rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mode_q  <= `HPA_MODE_RST;
         vol_q   <= `HPA_VOL_RST;
         float_q <= `HPA_FLOAT_RST;
         test_q  <= `HPA_TEST_RST;
         rdata   <= 8'h00;
      end else begin
         mode_q  <= mode_d;
         vol_q   <= vol_d;
         float_q <= float_d;
         test_q  <= test_d;
         rdata   <= rdata_d;
      end
   end

   chk_soft_reset_all: assert property (@(posedge clk_sys) disable iff (!rstn)
      soft_rst |=> (mode_q == `HPA_MODE_RST) && (vol_q == `HPA_VOL_RST) &&
                   (float_q == `HPA_FLOAT_RST) && (test_q == `HPA_TEST_RST))
      else $error("registers not restored by soft reset");

   chk_mode_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
      ($past(addr) == `HPA_REG_MODE) |-> (rdata[5:2] == 4'h0) && (rdata[1] == $past(thermal)))
      else $error("mode readback reserved or thermal bit wrong");

   chk_vol_write: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wr_en && !soft_rst && addr == `HPA_REG_VOL) |=> vol_q == ($past(wdata) & `HPA_VOL_WMASK))
      else $error("volume write not stored");

   chk_mode_write: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wr_en && !soft_rst && addr == `HPA_REG_MODE) |=>
         (mode_q[7] == $past(wdata[7])) && (mode_q[6] == $past(wdata[6])) &&
         (mode_q[0] == $past(wdata[0])) && (mode_q[5:1] == 5'h00))
      else $error("mode write not stored");

endmodule

/* tb/hpa_bus_master.sv */
/*
 * Bus master model for the amplifier control port: start, stop, byte write
 * and byte read on an open-drain data line, bus clock period 800 ns.
 * Assumes the bench resolves the data wire with a pull-up.
 */
`timescale 1ns/10ps

module hpa_bus_master (
   // bus pins
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   // clock stands high between frames
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   // pin changes may land on a system clock edge, so they are non-blocking
   task automatic start();
      #200 sda_low <= 1'b1;
      #200 scl <= 1'b0;
   endtask

   task automatic stop();
      #100 sda_low <= 1'b1;
      #300 scl <= 1'b1;
      #200 sda_low <= 1'b0;
      #200;
   endtask

   // data changes only while the clock is low
   task automatic wbyte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #100 sda_low <= !b[i];
         #300 scl <= 1'b1;
         #400 scl <= 1'b0;
      end
      #100 sda_low <= 1'b0;
      #300 scl <= 1'b1;
      #200 ack = (sda === 1'b0);
      #200 scl <= 1'b0;
   endtask

   task automatic rbyte(output logic [7:0] b, input logic last);
      for (int i = 7; i >= 0; i--) begin
         #400 scl <= 1'b1;
         #200 b[i] = sda;
         #200 scl <= 1'b0;
      end
      #100 sda_low <= !last;
      #300 scl <= 1'b1;
      #400 scl <= 1'b0;
      #100 sda_low <= 1'b0;
   endtask
endmodule

/* tb/headphone_amp_i2c_register_port_test.sv */
/*
 * Self-checking bench for the amplifier control port: register access over
 * the bus, refusals, thermal flag and general-call reset.
 * Assumes the bus master model and the design files are compiled first.
 */
`timescale 1ns/10ps
`include "hpa_params.svh"

module headphone_amp_i2c_register_port_test;
   logic       clk_sys = 1'b0;
   logic       rstn;
   logic       thermal_in;
   logic       scl;
   logic       sda_low;
   logic       sda_out;
   logic       sda_oe;
   logic       left_amp_enable;
   logic       right_amp_enable;
   logic       soft_shutdown;
   logic       mute_left;
   logic       mute_right;
   logic [4:0] volume_level;
   logic       float_left;
   logic       float_right;
   logic [7:0] test_value;
   wire        sda;
   int         n_mismatch = 0;
   int         n_tests = 0;

   always #50 clk_sys = ~clk_sys;

   // pulled-up wire, low when either party pulls it
   assign sda = !(sda_low || (sda_oe && !sda_out));

   hpa_bus_master m (
      .scl     (scl),
      .sda_low (sda_low),
      .sda     (sda)
   );

   hpa_i2c_target i_dut (
      .clk_sys          (clk_sys),
      .rstn             (rstn),
      .scl_in           (scl),
      .sda_in           (sda),
      .sda_out          (sda_out),
      .sda_oe           (sda_oe),
      .thermal_in       (thermal_in),
      .left_amp_enable  (left_amp_enable),
      .right_amp_enable (right_amp_enable),
      .soft_shutdown    (soft_shutdown),
      .mute_left        (mute_left),
      .mute_right       (mute_right),
      .volume_level     (volume_level),
      .float_left       (float_left),
      .float_right      (float_right),
      .test_value       (test_value)
   );

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // one frame: address byte, then optional further bytes, acks compared
   task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                        input int n, input logic [2:0] acks);
      logic a;
      m.start();
      m.wbyte(b0, a);
      check({7'h00, a}, {7'h00, acks[2]});
      if (n > 1) begin
         m.wbyte(b1, a);
         check({7'h00, a}, {7'h00, acks[1]});
      end
      if (n > 2) begin
         m.wbyte(b2, a);
         check({7'h00, a}, {7'h00, acks[0]});
      end
      m.stop();
   endtask

   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      frame({`HPA_TARGET_ADDR, 1'b0}, ptr, d, 3, 3'b111);
   endtask

   task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
      logic       a;
      logic [7:0] b;
      frame({`HPA_TARGET_ADDR, 1'b0}, ptr, 8'h00, 2, 3'b110);
      m.start();
      m.wbyte({`HPA_TARGET_ADDR, 1'b1}, a);
      check({7'h00, a}, 8'h01);
      // acked first byte, then the same register again
      m.rbyte(b, 1'b0);
      check(b, exp);
      m.rbyte(b, 1'b1);
      check(b, exp);
      m.stop();
   endtask

   task automatic defaults();
      rd(8'h01, `HPA_MODE_RST);
      rd(8'h02, `HPA_VOL_RST);
      rd(8'h03, `HPA_FLOAT_RST);
      rd(8'h04, `HPA_CHIP_ID);
      rd(8'h06, `HPA_TEST_RST);
      check({left_amp_enable, right_amp_enable, soft_shutdown, mute_left, mute_right,
             float_left, float_right, 1'b0}, 8'h18);
      check({3'h0, volume_level}, 8'h00);
   endtask

   initial begin
      #5_000_000;
      n_mismatch++;
      $display("ERROR at %0t: watchdog expired", $time);
      complete_run();
   end

   initial begin
      logic [7:0] empty [4];
      logic [7:0] other [3];
      empty      = '{8'h00, 8'h05, 8'h07, 8'hF8};
      other      = '{8'hC2, 8'h40, 8'hE0};
      rstn       <= 1'b0;
      thermal_in <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      #2000;
      defaults();
      $display("test reset values done");

      wr(8'hF9, 8'hFF);
      rd(8'h01, 8'hC1);
      check({5'h00, left_amp_enable, right_amp_enable, soft_shutdown}, 8'h07);
      wr(8'h01, 8'h40);
      check({5'h00, left_amp_enable, right_amp_enable, soft_shutdown}, 8'h02);
      $display("test mode register done");

      @(posedge clk_sys);
      thermal_in <= 1'b1;
      rd(8'h01, 8'h42);
      @(posedge clk_sys);
      thermal_in <= 1'b0;
      rd(8'h01, 8'h40);
      $display("test thermal flag done");

      wr(8'h02, 8'h3F);
      rd(8'h02, 8'h3E);
      wr(8'h03, 8'hFF);
      rd(8'h03, 8'h03);
      wr(8'h06, 8'hA5);
      rd(8'h06, 8'hA5);
      wr(8'h04, 8'h5A);
      rd(8'h04, `HPA_CHIP_ID);
      check({mute_left, mute_right, float_left, float_right, 4'h0}, 8'h30);
      check({3'h0, volume_level}, 8'h1F);
      check(test_value, 8'hA5);
      $display("test register map done");

      foreach (empty[i]) begin
         frame({`HPA_TARGET_ADDR, 1'b0}, empty[i], 8'h00, 2, 3'b100);
         frame({`HPA_TARGET_ADDR, 1'b1}, 8'h00, 8'h00, 1, 3'b000);
      end
      foreach (other[i])
         frame(other[i], 8'h01, 8'h00, 2, 3'b000);
      rd(8'h02, 8'h3E);
      $display("test refusals done");

      frame(8'h01, 8'h06, 8'h00, 1, 3'b000);
      frame(8'h00, 8'h05, 8'h00, 2, 3'b100);
      rd(8'h01, 8'h40);
      frame(8'h00, `HPA_GCALL_RESET, 8'h00, 2, 3'b110);
      repeat (10) @(posedge clk_sys);
      defaults();
      $display("test general call reset done");
      complete_run();
   end
endmodule
